// ==== hw/fih_framer_irq.sv ====
// Receive framer interrupt enable and status hierarchy
//
// Strobed register access was chosen for this implementation.
module fih_framer_irq (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Register port
  input  wire fih_pkg::fih_bus_req_t bus_req,
  output fih_pkg::fih_byte_t       rdata,
  // Receive E3 source events
  input  wire fih_pkg::fih_rx_evt_t rx_evt,
  // Requests of neighbouring blocks
  input  wire fih_pkg::fih_blk_req_t blk_req,
  // Interrupt requests
  output logic                     framer_req,
  output logic                     irq
);
  import fih_pkg::*;

  typedef struct packed {
    fih_byte_t  rx_en1;
    fih_byte_t  fb_en;
    fih_byte_t  op_en_hi;
    fih_byte_t  sum_mask;
    logic       ssm_en;
    logic [1:0] ssm_mf;
    logic [3:0] received_sync_quality;
    logic       ssm_seen;
    fih_byte_t  rdata;
  } fih_st_t;

  fih_st_t   s_reg;
  fih_st_t   s_next;

  fih_byte_t rx_set;
  fih_byte_t rx_clr;
  fih_byte_t rx_flags;
  fih_byte_t sec_set;
  fih_byte_t sec_clr;
  fih_byte_t sec_flags;
  fih_byte_t sum_set;
  fih_byte_t sum_clr;
  fih_byte_t sum_flags;
  fih_byte_t fb_stat;
  fih_byte_t op_hi;
  fih_byte_t op_lo;
  fih_byte_t rd_mux;
  logic      ssm_chg;
  logic      wr_hit;
  logic      rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status banks

  fih_sticky u_rx_stat (
    .clk      (clk),
    .nrst     (nrst),
    .set_bits (rx_set),
    .clr_bits (rx_clr),
    .flags    (rx_flags)
  );

  fih_sticky u_sec_stat (
    .clk      (clk),
    .nrst     (nrst),
    .set_bits (sec_set),
    .clr_bits (sec_clr),
    .flags    (sec_flags)
  );

  fih_sticky u_sum_stat (
    .clk      (clk),
    .nrst     (nrst),
    .set_bits (sum_set),
    .clr_bits (sum_clr),
    .flags    (sum_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source events

  assign wr_hit = bus_req.wr;
  assign rd_hit = bus_req.rd;

  // The first message after enabling has nothing to be compared with
  assign ssm_chg = rx_evt.ssm_valid && s_reg.ssm_en && s_reg.ssm_seen &&
                   (rx_evt.ssm_value != s_reg.received_sync_quality);

  always_comb begin
    rx_set            = RST_BYTE;
    rx_set[B_SSM_CHG] = ssm_chg;
    rx_set[B_SSM_OOO] = rx_evt.ooo && s_reg.ssm_en;
    rx_set[B_FA_CHG]  = rx_evt.fa_chg;
    rx_set[B_OOF]     = rx_evt.oof;
    rx_set[B_LOF]     = rx_evt.lof;
    rx_set[B_LOS]     = rx_evt.los;
    rx_set[B_AIS]     = rx_evt.ais;
  end

  // Reading the status byte clears it; the read data holds the old value
  assign rx_clr = (rd_hit && bus_req.addr == OFS_RX_STAT1) ? ALL_ONES : RST_BYTE;

  always_comb begin
    sec_set           = RST_BYTE;
    sec_set[B_FB_SEC] = blk_req.one_sec;
  end

  assign sec_clr = (rd_hit && bus_req.addr == OFS_FB_STAT) ? ALL_ONES : RST_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // Block level status, derived without storage so it drops with its sources

  always_comb begin
    fb_stat            = RST_BYTE;
    fb_stat[B_FB_RX]   = |(rx_flags & s_reg.rx_en1);
    fb_stat[B_FB_PLCP] = blk_req.plcp;
    fb_stat[B_FB_TX]   = blk_req.tx_framer;
    fb_stat[B_FB_SEC]  = sec_flags[B_FB_SEC];
  end

  always_comb begin
    op_hi            = RST_BYTE;
    op_hi[B_OP_FRM]  = |(fb_stat & s_reg.fb_en);
    op_hi[B_OP_LIJ]  = blk_req.liu;
  end

  always_comb begin
    op_lo             = RST_BYTE;
    op_lo[B_LO_RXBUS] = blk_req.rx_bus;
    op_lo[B_LO_RXPRC] = blk_req.rx_proc;
    op_lo[B_LO_TXBUS] = blk_req.tx_bus;
    op_lo[B_LO_TXPRC] = blk_req.tx_proc;
  end

  assign framer_req = op_hi[B_OP_FRM] && s_reg.op_en_hi[B_OP_FRM];

  ////////////////////////////////////////////////////////////////////////////
  // Summary status: sticky, write one to clear, masked onto irq

  always_comb begin
    sum_set             = RST_BYTE;
    sum_set[B_SUM_FRM]  = framer_req;
    sum_set[B_SUM_LIJ]  = op_hi[B_OP_LIJ] && s_reg.op_en_hi[B_OP_LIJ];
    sum_set[B_SUM_CELL] = |op_lo;
  end

  assign sum_clr = (wr_hit && bus_req.addr == OFS_SUM_STAT) ?
                   (bus_req.wdata & SUM_WMASK) : RST_BYTE;

  assign irq = |(sum_flags & s_reg.sum_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  always_comb begin
    rd_mux = RST_BYTE;
    case (bus_req.addr)
      OFS_OP_STAT_HI: rd_mux = op_hi;
      OFS_OP_STAT_LO: rd_mux = op_lo;
      OFS_OP_EN_HI:   rd_mux = s_reg.op_en_hi;
      OFS_SUM_STAT:   rd_mux = sum_flags;
      OFS_SUM_MASK:   rd_mux = s_reg.sum_mask;
      OFS_FB_EN:      rd_mux = s_reg.fb_en;
      OFS_FB_STAT:    rd_mux = fb_stat;
      OFS_RX_EN1:     rd_mux = s_reg.rx_en1;
      OFS_RX_STAT1:   rd_mux = rx_flags;
      OFS_RX_SSM: begin
        rd_mux[B_SSM_EN]           = s_reg.ssm_en;
        rd_mux[B_SSM_MF +: 2]      = s_reg.ssm_mf;
        rd_mux[3:0]                = s_reg.received_sync_quality;
      end
      default:        rd_mux = RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;

    // Read data stands for one cycle only
    s_next.rdata = rd_hit ? rd_mux : RST_BYTE;

    if (wr_hit) begin
      case (bus_req.addr)
        OFS_RX_EN1: begin
          s_next.rx_en1 = bus_req.wdata & RX_EN1_WMASK;
        end
        OFS_FB_EN: begin
          s_next.fb_en = bus_req.wdata & FB_EN_WMASK;
        end
        OFS_OP_EN_HI: begin
          s_next.op_en_hi = bus_req.wdata & OP_EN_WMASK;
        end
        OFS_SUM_MASK: begin
          s_next.sum_mask = bus_req.wdata & SUM_WMASK;
        end
        OFS_RX_SSM: begin
          s_next.ssm_en = bus_req.wdata[B_SSM_EN];
        end
        default: begin
        end
      endcase
    end

    // Disabling forgets the last message so the next enable starts clean
    if (!s_reg.ssm_en) begin
      s_next.ssm_seen = 1'b0;
    end

    if (rx_evt.ssm_valid && s_reg.ssm_en) begin
      s_next.received_sync_quality = rx_evt.ssm_value;
      s_next.ssm_mf                = rx_evt.ssm_mf;
      s_next.ssm_seen              = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg.rx_en1                <= RST_BYTE;
      s_reg.fb_en                 <= RST_BYTE;
      s_reg.op_en_hi              <= RST_BYTE;
      s_reg.sum_mask              <= RST_BYTE;
      s_reg.ssm_en                <= 1'b0;
      s_reg.ssm_mf                <= 2'h0;
      s_reg.received_sync_quality <= 4'h0;
      s_reg.ssm_seen              <= 1'b0;
      s_reg.rdata                 <= RST_BYTE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_ssm_chg_sets: assert property (
    @(posedge clk) disable iff (!nrst)
    ssm_chg |=> rx_flags[B_SSM_CHG])
    else $error("SSM change did not set its status bit");

  a_ssm_full_path: assert property (
    @(posedge clk) disable iff (!nrst)
    (ssm_chg && s_reg.rx_en1[B_SSM_CHG] && s_reg.fb_en[B_FB_RX] &&
     s_reg.op_en_hi[B_OP_FRM] && !wr_hit) |=> framer_req)
    else $error("Enabled SSM change raised no framer request");

  a_src_en_write: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_hit && bus_req.addr == OFS_RX_EN1) |=>
      (s_reg.rx_en1 == ($past(bus_req.wdata) & RX_EN1_WMASK)) && !s_reg.rx_en1[7])
    else $error("Receive source enable write not stored");

  a_fb_en_write: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_hit && bus_req.addr == OFS_FB_EN) |=>
      s_reg.fb_en[B_FB_RX] == $past(bus_req.wdata[B_FB_RX]))
    else $error("Framer block enable bit 7 not stored");

  a_op_framer_bit: assert property (
    @(posedge clk) disable iff (!nrst)
    (rx_flags[B_SSM_CHG] && s_reg.rx_en1[B_SSM_CHG] && s_reg.fb_en[B_FB_RX])
      |-> op_hi[B_OP_FRM])
    else $error("Framer bit of operational status missing");

  a_op_lo_read: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd_hit && bus_req.addr == OFS_OP_STAT_LO) |=>
      rdata == {$past(blk_req.rx_bus), 2'h0, $past(blk_req.rx_proc),
                $past(blk_req.tx_bus), 2'h0, $past(blk_req.tx_proc)})
    else $error("Operational byte 0 read data wrong");

  a_fb_rx_stat: assert property (
    @(posedge clk) disable iff (!nrst)
    (rx_flags[B_SSM_CHG] && s_reg.rx_en1[B_SSM_CHG]) |-> fb_stat[B_FB_RX])
    else $error("Receive framer block status missing");

  a_framer_gate: assert property (
    @(posedge clk) disable iff (!nrst)
    !s_reg.op_en_hi[B_OP_FRM] |-> !framer_req)
    else $error("Framer request not gated by operational enable");

  a_clear_on_read: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd_hit && bus_req.addr == OFS_RX_STAT1 && rx_set == RST_BYTE) |=>
      (rx_flags == RST_BYTE) && (rdata == $past(rx_flags)))
    else $error("Receive status not cleared by its read");

  a_ssm_capture: assert property (
    @(posedge clk) disable iff (!nrst)
    (rx_evt.ssm_valid && s_reg.ssm_en) |=>
      s_reg.received_sync_quality == $past(rx_evt.ssm_value))
    else $error("Received SSM not captured");

  a_block_drop: assert property (
    @(posedge clk) disable iff (!nrst)
    ((rx_flags & s_reg.rx_en1) == RST_BYTE && !blk_req.plcp &&
     !blk_req.tx_framer && !sec_flags[B_FB_SEC]) |-> !fb_stat[B_FB_RX] && !op_hi[B_OP_FRM])
    else $error("Block status held with no pending source");

  a_rdata_idle: assert property (
    @(posedge clk) disable iff (!nrst)
    !rd_hit |=> rdata == RST_BYTE)
    else $error("Read data present without a read");

  a_op_en_write: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_hit && bus_req.addr == OFS_OP_EN_HI) |=>
      (s_reg.op_en_hi == ($past(bus_req.wdata) & OP_EN_WMASK)))
    else $error("Operational enable write not stored");

  a_ssm_off_ignored: assert property (
    @(posedge clk) disable iff (!nrst)
    (rx_evt.ssm_valid && !s_reg.ssm_en) |=>
      $stable(s_reg.received_sync_quality))
    else $error("SSM value taken while extraction is off");

  a_irq_raise: assert property (
    @(posedge clk) disable iff (!nrst)
    (framer_req && s_reg.sum_mask[B_SUM_FRM] && !wr_hit) |=> irq)
    else $error("Masked-in framer request raised no interrupt");

  // Out-of-order reports mean nothing while extraction is off
  a_ooo_gated: assert property (
    @(posedge clk) disable iff (!nrst)
    (!s_reg.ssm_en && !rx_flags[B_SSM_OOO]) |=> !rx_flags[B_SSM_OOO])
    else $error("Out-of-order status set while extraction is off");

  a_sec_read_clear: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd_hit && bus_req.addr == OFS_FB_STAT && !blk_req.one_sec) |=>
      !sec_flags[B_FB_SEC])
    else $error("One-second status not cleared by its read");

endmodule // fih_framer_irq

// ==== hw/fih_pkg.sv ====
// Constants, register map and carrier types of the framer interrupt hierarchy
package fih_pkg;

  typedef logic [15:0] fih_addr_t;
  typedef logic [7:0]  fih_byte_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam fih_addr_t OFS_OP_STAT_HI = 16'h0112;
  localparam fih_addr_t OFS_OP_STAT_LO = 16'h0113;
  localparam fih_addr_t OFS_OP_EN_HI   = 16'h0116;
  localparam fih_addr_t OFS_SUM_STAT   = 16'h0118;
  localparam fih_addr_t OFS_SUM_MASK   = 16'h0119;
  localparam fih_addr_t OFS_FB_EN      = 16'h1104;
  localparam fih_addr_t OFS_FB_STAT    = 16'h1105;
  localparam fih_addr_t OFS_RX_EN1     = 16'h1112;
  localparam fih_addr_t OFS_RX_STAT1   = 16'h1114;
  localparam fih_addr_t OFS_RX_SSM     = 16'h112c;

  ////////////////////////////////////////////////////////////////////////////
  // Receive E3 source bits (enable and status share the layout)
  localparam int B_SSM_CHG  = 6;
  localparam int B_SSM_OOO  = 5;
  localparam int B_FA_CHG   = 4;
  localparam int B_OOF      = 3;
  localparam int B_LOF      = 2;
  localparam int B_LOS      = 1;
  localparam int B_AIS      = 0;
  // Framer block enable and status
  localparam int B_FB_RX    = 7;
  localparam int B_FB_PLCP  = 6;
  localparam int B_FB_TX    = 1;
  localparam int B_FB_SEC   = 0;
  // Operational block byte 1
  localparam int B_OP_LIJ   = 3;
  localparam int B_OP_FRM   = 2;
  // Operational block byte 0
  localparam int B_LO_RXBUS = 7;
  localparam int B_LO_RXPRC = 4;
  localparam int B_LO_TXBUS = 3;
  localparam int B_LO_TXPRC = 0;
  // Received sync register fields
  localparam int B_SSM_EN   = 7;
  localparam int B_SSM_MF   = 5;
  // Summary status and mask
  localparam int B_SUM_FRM  = 0;
  localparam int B_SUM_LIJ  = 1;
  localparam int B_SUM_CELL = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Writable bits and reset values
  localparam fih_byte_t RX_EN1_WMASK = 8'h7f;
  localparam fih_byte_t FB_EN_WMASK  = 8'hc3;
  localparam fih_byte_t OP_EN_WMASK  = 8'h0c;
  localparam fih_byte_t SUM_WMASK    = 8'h07;
  localparam fih_byte_t RST_BYTE     = 8'h00;
  localparam fih_byte_t ALL_ONES     = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    fih_addr_t addr;
    fih_byte_t wdata;
    logic      wr;
    logic      rd;
  } fih_bus_req_t;

  typedef struct packed {
    logic       ssm_valid;
    logic [3:0] ssm_value;
    logic [1:0] ssm_mf;
    logic       ooo;
    logic       fa_chg;
    logic       oof;
    logic       lof;
    logic       los;
    logic       ais;
  } fih_rx_evt_t;

  typedef struct packed {
    logic liu;
    logic plcp;
    logic tx_framer;
    logic one_sec;
    logic rx_bus;
    logic rx_proc;
    logic tx_bus;
    logic tx_proc;
  } fih_blk_req_t;

endpackage

// ==== hw/fih_sticky.sv ====
// Eight sticky flags: set wins over clear
module fih_sticky (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Set and clear per bit
  input  wire fih_pkg::fih_byte_t set_bits,
  input  wire fih_pkg::fih_byte_t clr_bits,
  // Held flags
  output fih_pkg::fih_byte_t     flags
);
  import fih_pkg::*;

  typedef struct packed {
    fih_byte_t flags;
  } fih_stk_st_t;

  fih_stk_st_t s_reg;
  fih_stk_st_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // An event in the clearing cycle must not be lost
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign s_next.flags[i] = set_bits[i] | (s_reg.flags[i] & ~clr_bits[i]);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg.flags <= RST_BYTE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flags = s_reg.flags;

endmodule // fih_sticky

// ==== sim/test_fih_framer_irq.sv ====
// Self-checking testbench of the framer interrupt hierarchy
module test_fih_framer_irq;
  timeunit 1ns;
  timeprecision 1ps;
  import fih_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Signals
  logic         clk;
  logic         nrst;
  fih_bus_req_t bus_req;
  fih_byte_t    rdata;
  fih_rx_evt_t  rx_evt;
  fih_blk_req_t blk_req;
  logic         framer_req;
  logic         irq;
  int           num_errors;
  int           total_checks;
  integer       seed;
  fih_byte_t    exp_q[$];
  logic         rd_d;
  logic [31:0]  r;
  fih_byte_t    b;
  logic         any;
  fih_byte_t    sacc;

  // Last entry is an unmapped place
  fih_addr_t regs[11] = '{OFS_OP_STAT_HI, OFS_OP_STAT_LO, OFS_OP_EN_HI, OFS_SUM_STAT,
    OFS_SUM_MASK, OFS_FB_EN, OFS_FB_STAT, OFS_RX_EN1, OFS_RX_STAT1, OFS_RX_SSM, 16'h0000};
  fih_byte_t wexp[11] = '{8'h00, 8'h00, 8'h0c, 8'h00, 8'h07, 8'hc3, 8'h00, 8'h7f, 8'h00,
    8'h80, 8'h00};

  fih_framer_irq DUT (
    .clk        (clk),
    .nrst       (nrst),
    .bus_req    (bus_req),
    .rdata      (rdata),
    .rx_evt     (rx_evt),
    .blk_req    (blk_req),
    .framer_req (framer_req),
    .irq        (irq)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input fih_byte_t seen, input fih_byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        chk(rdata, 8'hxx);
      end else begin
        chk(rdata, exp_q.pop_front());
      end
    end
    rd_d <= bus_req.rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and event drivers
  task automatic wr(input fih_addr_t a, input fih_byte_t d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask

  task automatic rd(input fih_addr_t a, input fih_byte_t e);
    exp_q.push_back(e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    bus_req <= '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    repeat (n) @(posedge clk);
  endtask

  // Looks at the two request lines mid-cycle, after all updates have landed
  task automatic flags(input fih_byte_t e);
    idle(1);
    @(negedge clk);
    chk({6'h00, framer_req, irq}, e);
    @(posedge clk);
  endtask

  function automatic fih_rx_evt_t ssm(input logic [3:0] v, input logic [1:0] m);
    ssm = '0;
    ssm.ssm_valid = 1'b1;
    ssm.ssm_value = v;
    ssm.ssm_mf = m;
  endfunction

  task automatic evt(input fih_rx_evt_t e);
    rx_evt <= e;
    idle(1);
    rx_evt <= '0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    bus_req = '0;
    rx_evt = '0;
    blk_req = '0;
    rd_d = 1'b0;
    seed = 32'h3566;
    sacc = 8'h00;
    num_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) rd(regs[i], RST_BYTE);
    // Ones everywhere: read-only places and unwritable bits must not take them
    foreach (regs[i]) wr(regs[i], ALL_ONES);
    foreach (regs[i]) rd(regs[i], wexp[i]);
    wr(OFS_SUM_MASK, 8'h01);
    flags(8'h00);
    // First value after enable is only stored, a repeat is no change
    evt(ssm(4'h5, 2'h2));
    evt(ssm(4'h5, 2'h2));
    rd(OFS_RX_SSM, 8'hc5);
    rd(OFS_RX_STAT1, 8'h00);
    idle(1);
    rx_evt <= ssm(4'h9, 2'h1);
    @(posedge clk);
    rx_evt <= '0;
    @(negedge clk);
    chk({6'h00, framer_req, irq}, 8'h02);
    @(negedge clk);
    chk({6'h00, framer_req, irq}, 8'h03);
    @(posedge clk);
    wr(OFS_OP_EN_HI, 8'h00);
    flags(8'h01);
    wr(OFS_SUM_MASK, 8'h00);
    flags(8'h00);
    wr(OFS_SUM_MASK, 8'h01);
    wr(OFS_OP_EN_HI, 8'h0c);
    flags(8'h03);
    // Service walk of the pending request
    rd(OFS_OP_STAT_HI, 8'h04);
    rd(OFS_OP_STAT_LO, 8'h00);
    rd(OFS_FB_STAT, 8'h80);
    rd(OFS_RX_STAT1, 8'h40);
    rd(OFS_RX_STAT1, 8'h00);
    rd(OFS_OP_STAT_HI, 8'h00);
    rd(OFS_RX_SSM, 8'ha9);
    rd(OFS_SUM_STAT, 8'h01);
    flags(8'h01);
    wr(OFS_SUM_STAT, 8'h01);
    flags(8'h00);
    // Extraction off: values ignored; back on: first value only stored
    wr(OFS_RX_SSM, 8'h00);
    evt(ssm(4'h3, 2'h0));
    rd(OFS_RX_SSM, 8'h29);
    wr(OFS_RX_SSM, 8'h80);
    evt(ssm(4'h3, 2'h0));
    rd(OFS_RX_STAT1, 8'h00);
    rd(OFS_RX_SSM, 8'h83);
    // Random source events and neighbour levels
    repeat (12) begin
      r = $random(seed);
      b = r[15:8];
      any = |r[5:0];
      // Summary bits: framer request, line interface, cell-level blocks
      sacc = sacc | {5'h00, |b[3:0], b[7], any | b[6] | b[5] | b[4]};
      rx_evt <= fih_rx_evt_t'({7'h00, r[5:0]});
      blk_req <= fih_blk_req_t'(b);
      idle(1);
      rx_evt <= '0;
      blk_req.one_sec <= 1'b0;
      rd(OFS_FB_STAT, {any, b[6], 4'h0, b[5], b[4]});
      rd(OFS_OP_STAT_HI, {4'h0, b[7], any | b[6] | b[5], 2'b00});
      rd(OFS_RX_STAT1, {2'b00, r[5:0]});
      rd(OFS_OP_STAT_LO, {b[3], 2'b00, b[2], b[1], 2'b00, b[0]});
      rd(OFS_OP_STAT_HI, {4'h0, b[7], b[6] | b[5], 2'b00});
    end
    blk_req <= '0;
    idle(2);
    rd(OFS_SUM_STAT, sacc);
    wr(OFS_SUM_STAT, 8'h07);
    rd(OFS_SUM_STAT, 8'h00);
    flags(8'h00);
    idle(3);
    end_sim();
  end

endmodule // test_fih_framer_irq
